//--- hw/pmc_clkrun_ctrl.sv
`timescale 1ns/1ns
`include "pmc_misc_map.svh"
// Clock run agent: decides whether to hold the bus clock running
module pmc_clkrun_ctrl import pmc_misc_pkg::*; (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic keep_clock,
  input  wire logic stop_request,
  input  wire logic busy,
  output logic      hold_run_q
);
  logic [3:0] hold_cnt_q;  // Stretch after a refused stop request
  // Assert the run request when a stop request comes while keeping the clock or still busy
  always_ff @(posedge clock) begin
    if (reset) begin
      hold_cnt_q <= 4'h0;
      hold_run_q <= 1'b0;
    end else if (stop_request && (keep_clock || busy)) begin
      hold_cnt_q <= `PMC_CLKRUN_HOLD_CYCLES;
      hold_run_q <= 1'b1;
    end else if (hold_cnt_q != 4'h0) begin
      hold_cnt_q <= hold_cnt_q - 4'h1;
      hold_run_q <= 1'b1;
    end else begin
      hold_run_q <= 1'b0;
    end
  end
endmodule : pmc_clkrun_ctrl

//--- hw/pmc_clock_gate.sv
`timescale 1ns/1ns
// Enable-style clock gate model; bypass forces the enable on
module pmc_clock_gate import pmc_misc_pkg::*; (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic bypass,
  input  wire logic want_run,
  output logic      gate_open_q
);
  // Register the enable so the gate never glitches
  always_ff @(posedge clock) begin
    if (reset) begin
      gate_open_q <= 1'b0;
    end else begin
      gate_open_q <= bypass | want_run;
    end
  end
endmodule : pmc_clock_gate

//--- hw/pmc_misc_config.sv
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "pmc_misc_map.svh"
// Functional notes
// - Upper sixteen bits read zero, ignore writes
// - Reserved low bits read zero, ignore writes
// - Bit 15 drives deep-off wake capability
// - Bit 13 drives light-sleep wake capability
// - Bit 10 drives light-sleep state capability
// - Capability bits survive bus reset, D3 exit
// - Bit 2 bypasses serial clock gating
// - Bit 1 bypasses bus clock gating
// - Bit 0 set refuses clock stop
// - Bit 0 clear permits clock stop
// - Power level encoded in two bits
module pmc_misc_config import pmc_misc_pkg::*; (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        bus_reset_input,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  input  wire logic        serial_clock_want,
  input  wire logic        bus_clock_want,
  input  wire logic        clock_stop_request,
  input  wire logic        bus_busy,
  output logic             wake_from_deep_off_support,
  output logic             wake_from_light_sleep_support,
  output logic             light_sleep_state_support,
  output logic             serial_clock_enable,
  output logic             bus_clock_enable,
  output logic             clock_run_hold,
  output logic [1:0]       current_power_level
);
  logic [31:0]       misc_q;          // Configuration word, stored bits only
  logic [31:0]       sticky_q;        // Capability bits, kept over the bus reset pin
  logic [2:0]        ctrl_q;          // Test and clock-run controls
  logic              wr_accept;       // A write takes effect at this edge
  logic [1:0]        level_q;         // Power level
  logic [1:0]        prev_level_q;    // Previous level for transition checks
  logic              rst_sync1_q;     // Bus reset pin, first stage
  logic              rst_sync2_q;     // Bus reset pin, second stage
  logic [31:0]       wmask;           // Byte lane write mask
  logic              hit_misc;        // Address decode
  logic              hit_level;       // Address decode
  pmc_bus_state_type state_q;         // Bus slave state
  logic              serial_gate_q;   // From serial gate
  logic              bus_gate_q;      // From bus gate
  logic              hold_q;          // From clock run agent
  logic              local_reset;     // Reset of non-sticky logic

  // Bus reset pin is asynchronous to us: two stages before use
  always_ff @(posedge clock) begin
    if (reset) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= bus_reset_input;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // Non-sticky state also resets on the bus reset pin
  assign local_reset = reset | rst_sync2_q;
  assign hit_misc    = (address == `PMC_MISC_CONFIG_OFFSET);
  assign hit_level   = (address == `PMC_POWER_LEVEL_OFFSET);
  // Writes land in the answer cycle, while the master still holds them
  assign wr_accept   = write && (state_q == pmc_done_type_s);
  // Two separately reset parts; reserved bits of both stay zero
  assign misc_q      = sticky_q | {29'h0, ctrl_q};

  // Expand byte enables into a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{byteenable[i]}};
    end
  end

  // Slave sequencing: every access is answered two cycles after it is seen
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= pmc_idle_type_s;
    end else begin
      case (state_q)
        pmc_idle_type_s: begin
          // Take a read or a write; the master holds it until answered
          if (read || write) begin
            state_q <= pmc_read_type_s;
          end
        end
        pmc_read_type_s: begin
          // Lookup cycle for both directions; read data registered here
          state_q <= pmc_done_type_s;
        end
        pmc_done_type_s: begin
          // Answer cycle; back to idle so a held strobe is not taken twice
          state_q <= pmc_idle_type_s;
        end
        default: begin
          // Illegal code: recover to idle
          state_q <= pmc_idle_type_s;
        end
      endcase
    end
  end

  // Waitrequest from a flop, low only in the answer cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      // Costs writes a wait state, but keeps the output glitch free
      waitrequest <= (state_q != pmc_read_type_s);
    end
  end

  // Register read data; reserved and upper bits are never stored
  always_ff @(posedge clock) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
      response <= 2'h0;
    end else if (state_q == pmc_read_type_s && read) begin
      if (hit_misc) begin
        readdata <= misc_q & `PMC_MISC_WRITE_MASK;
        response <= 2'h0;
      end else if (hit_level) begin
        readdata <= {30'h0, level_q};
        response <= 2'h0;
      end else begin
        // Unmapped: zero data with slave error
        readdata <= 32'h0000_0000;
        response <= 2'h2;
      end
    end
  end

  // Sticky capability bits: only the core reset touches them
  always_ff @(posedge clock) begin
    if (reset) begin
      sticky_q <= `PMC_MISC_RESET_VALUE & `PMC_MISC_STICKY_MASK;
    end else if (wr_accept && hit_misc) begin
      // Writes to reserved bits drop through the mask
      sticky_q <= ((sticky_q & ~wmask) | (writedata & wmask))
                  & `PMC_MISC_STICKY_MASK;
    end
  end

  // Test and clock-run controls clear on either reset
  always_ff @(posedge clock) begin
    if (local_reset) begin
      ctrl_q <= 3'(`PMC_MISC_RESET_VALUE);
    end else if (wr_accept && hit_misc && byteenable[0]) begin
      ctrl_q <= writedata[2:0];
    end
  end

  // Power level register; D3 to D0 does not touch capability bits
  always_ff @(posedge clock) begin
    if (local_reset) begin
      level_q      <= `PMC_POWER_RESET_VALUE;
      prev_level_q <= `PMC_POWER_RESET_VALUE;
    end else begin
      prev_level_q <= level_q;
      // The unsupported level is refused and the old level kept
      if (wr_accept && hit_level && byteenable[0] &&
          writedata[1:0] != `PMC_LEVEL_UNSUPPORTED) begin
        level_q <= writedata[1:0];
      end
    end
  end

  // Serial clock gate with bypass
  pmc_clock_gate u_serial_gate (
    .clock       (clock),
    .reset       (reset),
    .bypass      (misc_q[`PMC_BIT_SERIAL_BYPASS]),
    .want_run    (serial_clock_want),
    .gate_open_q (serial_gate_q)
  );

  // Bus clock gate with bypass
  pmc_clock_gate u_bus_gate (
    .clock       (clock),
    .reset       (reset),
    .bypass      (misc_q[`PMC_BIT_BUS_BYPASS]),
    .want_run    (bus_clock_want),
    .gate_open_q (bus_gate_q)
  );

  // Clock run agent: refuse stops when kept or busy, and through the stretch after
  pmc_clkrun_ctrl u_clkrun (
    .clock        (clock),
    .reset        (local_reset),
    .keep_clock   (misc_q[`PMC_BIT_KEEP_CLOCK]),
    .stop_request (clock_stop_request),
    .busy         (bus_busy),
    .hold_run_q   (hold_q)
  );

  // Outputs straight from flip-flops
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_from_deep_off_support    <= 1'b0;
      wake_from_light_sleep_support <= 1'b1;
      light_sleep_state_support     <= 1'b1;
      serial_clock_enable           <= 1'b0;
      bus_clock_enable              <= 1'b0;
      clock_run_hold                <= 1'b0;
      current_power_level           <= `PMC_POWER_RESET_VALUE;
    end else begin
      wake_from_deep_off_support    <= misc_q[`PMC_BIT_DEEP_OFF_WAKE];
      wake_from_light_sleep_support <= misc_q[`PMC_BIT_LIGHT_WAKE];
      light_sleep_state_support     <= misc_q[`PMC_BIT_LIGHT_SLEEP];
      serial_clock_enable           <= serial_gate_q;
      bus_clock_enable              <= bus_gate_q;
      clock_run_hold                <= hold_q;
      current_power_level           <= level_q;
    end
  end

  // Checks
  // Upper half of a configuration word read is always zero
  chk_upper_zero: assert property (@(posedge clock) disable iff (reset)
    (state_q == pmc_done_type_s && hit_misc) |-> readdata[31:16] == 16'h0)
    else $error("upper bits not zero");
  // Reserved low bits of every answer are zero
  chk_reserved_zero: assert property (@(posedge clock) disable iff (reset)
    (state_q == pmc_done_type_s) |-> (readdata[14] == 1'b0 && readdata[12:11] == 2'h0 &&
    readdata[9:3] == 7'h0))
    else $error("reserved bits not zero");
  // Nothing but the writable bits is ever stored
  chk_stored_mask: assert property (@(posedge clock) disable iff (reset)
    (misc_q & ~`PMC_MISC_WRITE_MASK) == 32'h0)
    else $error("reserved bit stored");
  // Capability outputs copy the stored bits a cycle later
  chk_deep_wake: assert property (@(posedge clock) disable iff (reset)
    ##1 wake_from_deep_off_support == $past(misc_q[15]))
    else $error("deep wake capability wrong");
  chk_light_wake: assert property (@(posedge clock) disable iff (reset)
    ##1 wake_from_light_sleep_support == $past(misc_q[13]))
    else $error("light wake capability wrong");
  chk_light_state: assert property (@(posedge clock) disable iff (reset)
    ##1 light_sleep_state_support == $past(misc_q[10]))
    else $error("light state capability wrong");
  // A write to lane 1 shows on the capability output two cycles on
  chk_deep_write: assert property (@(posedge clock) disable iff (reset)
    (wr_accept && hit_misc && byteenable[1]) |->
    ##2 wake_from_deep_off_support == $past(writedata[`PMC_BIT_DEEP_OFF_WAKE], 2))
    else $error("deep wake capability not written");
  // Bus reset pin leaves the capability bits alone
  chk_sticky_bits: assert property (@(posedge clock) disable iff (reset)
    (rst_sync2_q && !(write && hit_misc)) |=> $stable(misc_q[15:10]))
    else $error("capability bits lost on bus reset");
  // Leaving deep-off for full-on leaves them alone too
  chk_d3_exit_sticky: assert property (@(posedge clock) disable iff (local_reset)
    (prev_level_q == `PMC_LEVEL_DEEP_OFF && level_q == `PMC_LEVEL_FULL_ON) |->
    $stable(misc_q[15:10]))
    else $error("capability bits lost on deep-off exit");
  // Bypass forces the serial gate open
  chk_serial_bypass: assert property (@(posedge clock) disable iff (local_reset)
    misc_q[2] |-> ##2 serial_clock_enable)
    else $error("serial bypass not honoured");
  // Without bypass or a request the serial gate stays shut
  chk_serial_gated: assert property (@(posedge clock) disable iff (local_reset)
    (!misc_q[`PMC_BIT_SERIAL_BYPASS] && !serial_clock_want) |-> ##2 !serial_clock_enable)
    else $error("serial gate open without cause");
  // Bypass forces the bus gate open
  chk_bus_bypass: assert property (@(posedge clock) disable iff (local_reset)
    misc_q[1] |-> ##2 bus_clock_enable)
    else $error("bus bypass not honoured");
  // Without bypass or a request the bus gate stays shut
  chk_bus_gated: assert property (@(posedge clock) disable iff (local_reset)
    (!misc_q[`PMC_BIT_BUS_BYPASS] && !bus_clock_want) |-> ##2 !bus_clock_enable)
    else $error("bus gate open without cause");
  // Keep bit set: a stop request is refused
  chk_keep_clock: assert property (@(posedge clock) disable iff (local_reset)
    (clock_stop_request && misc_q[0]) |-> ##2 clock_run_hold)
    else $error("clock stop not refused");
  // Keep bit clear and not busy: a stop request gets through after the stretch
  chk_permit_stop: assert property (@(posedge clock) disable iff (local_reset)
    (clock_stop_request && !misc_q[`PMC_BIT_KEEP_CLOCK] && !bus_busy) [*4] |=> !hold_q)
    else $error("clock stop wrongly refused");
  // Core reset loads the defined value
  chk_reset_value: assert property (@(posedge clock)
    $fell(reset) |-> misc_q == `PMC_MISC_RESET_VALUE)
    else $error("reset value wrong");
  // The unsupported level is never entered
  chk_level_code: assert property (@(posedge clock) disable iff (local_reset)
    level_q != `PMC_LEVEL_UNSUPPORTED)
    else $error("unsupported level entered");
  // A write of the unsupported level leaves the level as it was
  chk_level_refused: assert property (@(posedge clock) disable iff (local_reset)
    (wr_accept && hit_level && writedata[1:0] == `PMC_LEVEL_UNSUPPORTED) |=>
    $stable(level_q))
    else $error("unsupported level write not refused");
  // Level output copies the level register a cycle later
  chk_level_output: assert property (@(posedge clock) disable iff (reset)
    ##1 current_power_level == $past(level_q))
    else $error("level output wrong");
endmodule : pmc_misc_config

//--- hw/pmc_misc_map.svh
`ifndef PMC_MISC_MAP_SVH
`define PMC_MISC_MAP_SVH
// Register byte offsets
`define PMC_MISC_CONFIG_OFFSET  8'hf0
`define PMC_POWER_LEVEL_OFFSET  8'hf8
// Field positions in the miscellaneous configuration word
`define PMC_BIT_DEEP_OFF_WAKE   15
`define PMC_BIT_LIGHT_WAKE      13
`define PMC_BIT_LIGHT_SLEEP     10
`define PMC_BIT_SERIAL_BYPASS   2
`define PMC_BIT_BUS_BYPASS      1
`define PMC_BIT_KEEP_CLOCK      0
// Writable bits and reset values
`define PMC_MISC_WRITE_MASK     32'h0000a407
`define PMC_MISC_STICKY_MASK    32'h0000a400
`define PMC_MISC_RESET_VALUE    32'h00002400
`define PMC_POWER_RESET_VALUE   2'h0
// Power level encodings
`define PMC_LEVEL_FULL_ON       2'h0
`define PMC_LEVEL_UNSUPPORTED   2'h1
`define PMC_LEVEL_LIGHT_SLEEP   2'h2
`define PMC_LEVEL_DEEP_OFF      2'h3
// Clock run request hold time in cycles
`define PMC_CLKRUN_HOLD_CYCLES  4'h2
`endif

//--- hw/pmc_misc_pkg.sv
package pmc_misc_pkg;
  // Power level of the function
  typedef enum logic [1:0] {
    pmc_full_on_type_e   = 2'h0,
    pmc_unsupp_type_e    = 2'h1,
    pmc_light_type_e     = 2'h2,
    pmc_deep_type_e      = 2'h3
  } pmc_level_type;
  // Bus slave states, one-hot
  typedef enum logic [2:0] {
    pmc_idle_type_s  = 3'h1,
    pmc_read_type_s  = 3'h2,
    pmc_done_type_s  = 3'h4
  } pmc_bus_state_type;
endpackage : pmc_misc_pkg

//--- tb/pmc_host_model.sv
`timescale 1ns/1ns
// Configuration host: Avalon master that drives the register bus
module pmc_host_model (
  input  wire logic        clock,
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  input  wire logic [1:0]  response
);
  // Idle bus from time zero
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end
  // Write held until waitrequest is seen low at a rising edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    write      <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    write     <= 1'b0;
    // Released lines show garbage, not the old value
    address   <= ~a;
    writedata <= ~d;
  endtask : bus_write
  // Read; data and response taken at the accepting edge only
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    address <= a;
    read    <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    d = readdata;
    r = response;
    read    <= 1'b0;
    address <= ~a;
  endtask : bus_read
endmodule : pmc_host_model

//--- tb/test_pci_misc_config_register.sv
`timescale 1ns/1ns
`include "pmc_misc_map.svh"
// Register-level tests of the miscellaneous configuration block
module test_pci_misc_config_register;
  logic        clock, reset, bus_reset_input;       // Clock and both resets
  logic [7:0]  address;                             // Bus address
  logic        read, write, waitrequest;            // Bus strobes
  logic [31:0] writedata, readdata, rd;             // Bus data
  logic [3:0]  byteenable;                          // Lane enables
  logic [1:0]  response, rr, level;                 // Response, power level
  logic        scw, bcw, stop_req, busy;            // Clock side inputs
  logic        wdeep, wlight, lsleep, sen, ben, hold; // Observed controls
  int          n_mismatch, checks, cycles;          // Counters
  logic [1:0]  lv_in [4] = '{2'h2, 2'h3, 2'h1, 2'h0}; // Levels written
  logic [1:0]  lv_ex [4] = '{2'h2, 2'h3, 2'h3, 2'h0}; // Code 01 is refused
  // Free-running clock, 4 ns period
  always #2 clock = ~clock;
  pmc_host_model host (.clock(clock), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response));
  pmc_misc_config dut (.clock(clock), .reset(reset), .bus_reset_input(bus_reset_input),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .serial_clock_want(scw), .bus_clock_want(bcw),
    .clock_stop_request(stop_req), .bus_busy(busy), .wake_from_deep_off_support(wdeep),
    .wake_from_light_sleep_support(wlight), .light_sleep_state_support(lsleep),
    .serial_clock_enable(sen), .bus_clock_enable(ben), .clock_run_hold(hold),
    .current_power_level(level));
  // Compare one value, report at once
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // Read a register and compare data and an OK response
  task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input string what);
    host.bus_read(a, rd, rr);
    check(rd, exp, what);
    check({30'h0, rr}, 32'h0, what);
  endtask : read_check
  // Controls packed: caps 15/13/10, gate enables, hold
  task automatic ctl_check(input logic [31:0] exp, input string what);
    // Long enough for the two-cycle stop stretch plus output flops
    repeat (8) @(posedge clock);
    check({26'h0, wdeep, wlight, lsleep, sen, ben, hold}, exp, what);
  endtask : ctl_check
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Hang guard, well above the run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    bus_reset_input = 1'b0;
    {scw, bcw, stop_req, busy} = 4'h0;
    {n_mismatch, checks} = '0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    read_check(`PMC_MISC_CONFIG_OFFSET, 32'h00002400, "reset value");
    ctl_check(32'h18, "controls after reset");
    $display("test reset done");
    stop_req <= 1'b1;
    host.bus_write(`PMC_MISC_CONFIG_OFFSET, 32'hffffffff, 4'hf);
    read_check(`PMC_MISC_CONFIG_OFFSET, 32'h0000a407, "all ones");
    ctl_check(32'h3f, "all controls set");
    host.bus_write(`PMC_MISC_CONFIG_OFFSET, 32'h0, 4'hf);
    read_check(`PMC_MISC_CONFIG_OFFSET, 32'h0, "all zero");
    ctl_check(32'h0, "all controls clear");
    $display("test controls done");
    host.bus_write(`PMC_MISC_CONFIG_OFFSET, 32'hffffffff, 4'h1);
    read_check(`PMC_MISC_CONFIG_OFFSET, 32'h00000007, "lane 0 only");
    host.bus_write(`PMC_MISC_CONFIG_OFFSET, 32'h0000ffff, 4'h2);
    read_check(`PMC_MISC_CONFIG_OFFSET, 32'h0000a407, "lane 1 only");
    for (int i = 0; i < 4; i++) begin
      host.bus_write(`PMC_POWER_LEVEL_OFFSET, {30'h0, lv_in[i]}, 4'hf);
      read_check(`PMC_POWER_LEVEL_OFFSET, {30'h0, lv_ex[i]}, "level read");
      check({30'h0, level}, {30'h0, lv_ex[i]}, "level output");
    end
    $display("test power level done");
    bus_reset_input <= 1'b1;
    repeat (4) @(posedge clock);
    bus_reset_input <= 1'b0;
    repeat (4) @(posedge clock);
    read_check(`PMC_MISC_CONFIG_OFFSET, 32'h0000a400, "after bus reset");
    host.bus_read(8'h10, rd, rr);
    check(rd, 32'h0, "unmapped data");
    check({30'h0, rr}, 32'h2, "unmapped response");
    $display("test bus reset and unmapped done");
    // Caps kept, controls cleared; stop request now let through
    ctl_check(32'h38, "controls after bus reset");
    {scw, bcw, busy} <= 3'h7;
    ctl_check(32'h3f, "gates wanted, busy");
    {scw, bcw, busy} <= 3'h0;
    ctl_check(32'h38, "gates idle again");
    $display("test clock gates done");
    tally_and_finish();
  end
endmodule : test_pci_misc_config_register
